// *** verilog/iosq_cfg.svh ***
`ifndef IOSQ_CFG_SVH
`define IOSQ_CFG_SVH
// ==========================================================
// Bus layout and status encodings
`define IOSQ_ADDR_W      24
`define IOSQ_DATA_W      32
`define IOSQ_SUB_W       8
`define IOSQ_SUB_LSB     0
`define IOSQ_VEC_STATUS  24'h000014
`define IOSQ_CC_OK       2'h0
`define IOSQ_CC_BUSY     2'h1
`define IOSQ_CC_NOTOP    2'h2
`define IOSQ_CC_UNDEF    2'h3
`define IOSQ_FIFO_DEPTH  8
// Event source codes held in the status word's top byte
`define IOSQ_EV_TERM     2'h0
`define IOSQ_EV_ATTN     2'h1
`define IOSQ_EV_PCI      2'h2
`endif

// *** verilog/iosq_pkg.sv ***
package iosq_pkg;
   // Host command codes
   typedef enum logic [2:0] {
      IOSQ_CMD_START,
      IOSQ_CMD_TEST,
      IOSQ_CMD_HALT,
      IOSQ_CMD_CHAN_CTRL,
      IOSQ_CMD_CTRL_RESET,
      IOSQ_CMD_ENABLE_INT,
      IOSQ_CMD_DISABLE_INT,
      IOSQ_CMD_UNDEF
   } iosq_cmd_type;
endpackage

// *** verilog/iosq_if.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iosq_cfg.svh"
// ==========================================================
// Host-to-channel link: command, answer, interrupt, memory write
interface iosq_if;
   import iosq_pkg::*;
   logic                     cmd_valid;
   iosq_cmd_type             cmd_op;
   logic [`IOSQ_ADDR_W-1:0]  cmd_addr;
   logic [`IOSQ_DATA_W-1:0]  cmd_data;
   logic                     cmd_done;
   logic [1:0]               cmd_cc;
   logic [`IOSQ_DATA_W-1:0]  cmd_status_addr;
   logic                     int_req;
   logic                     int_ack;
   logic                     mem_wr;
   logic [`IOSQ_ADDR_W-1:0]  mem_addr;
   logic [`IOSQ_DATA_W-1:0]  mem_data;
   modport channel (input cmd_valid, cmd_op, cmd_addr, cmd_data, int_ack,
                    output cmd_done, cmd_cc, cmd_status_addr, int_req, mem_wr, mem_addr, mem_data);
   modport host (output cmd_valid, cmd_op, cmd_addr, cmd_data, int_ack,
                 input cmd_done, cmd_cc, cmd_status_addr, int_req, mem_wr, mem_addr, mem_data);
endinterface
`default_nettype wire

// *** verilog/iosq_channel.sv ***
// ==========================================================
`timescale 1ns/1ps
`default_nettype none
`include "iosq_cfg.svh"
module iosq_channel
   import iosq_pkg::*;
#(
   parameter int DEPTH = `IOSQ_FIFO_DEPTH
) (
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   iosq_if.channel                      bus,
   input  wire logic                    operational,
   input  wire logic                    ev_valid,
   input  wire logic [`IOSQ_SUB_W-1:0]  ev_src_addr,
   input  wire logic [1:0]              ev_kind,
   input  wire logic                    ev_device_end,
   input  wire logic                    ev_area_full,
   input  wire logic                    ev_block_end,
   input  wire logic [15:0]             ev_residue,
   output logic                         ctl_start,
   output logic [`IOSQ_SUB_W-1:0]       ctl_sub,
   output logic [`IOSQ_DATA_W-1:0]      ctl_cla,
   output logic                         ctl_halt,
   output logic                         ctl_reset,
   output logic                         xfer_done
);
   localparam int SUBS = 1 << `IOSQ_SUB_W;
   localparam int PW   = $clog2(DEPTH);

   // Pointer wrap arithmetic only works for a power-of-two depth
   if (DEPTH < 2 || (1 << PW) != DEPTH) begin : g_depth_check
      $error("DEPTH must be a power of two");
   end

   // ==========================================================
   // Subchannel state, eight-bit index
   logic [SUBS-1:0]           busy_q;
   logic [SUBS-1:0]           pend_q;
   logic [`IOSQ_DATA_W-1:0]   stat_q [SUBS];
   logic [`IOSQ_DATA_W-1:0]   buf_addr_q;
   logic [`IOSQ_DATA_W-1:0]   vec_q;
   logic                      int_en_q;
   logic [`IOSQ_SUB_W-1:0]    fifo_q [DEPTH];
   logic [PW:0]               wr_q;
   logic [PW:0]               rd_q;
   logic                      store_q;
   logic                      store_addr_q;
   logic [`IOSQ_SUB_W-1:0]    store_sub_q;

   logic [`IOSQ_SUB_W-1:0]    sub;
   logic                      is_cmd;
   logic                      fifo_empty;
   logic                      pop;
   logic                      push;
   logic [`IOSQ_SUB_W-1:0]    head;
   logic                      ack_go;

   assign sub        = bus.cmd_addr[`IOSQ_SUB_LSB +: `IOSQ_SUB_W];
   assign is_cmd     = bus.cmd_valid && !store_q && !store_addr_q;
   assign fifo_empty = (wr_q == rd_q);
   assign head       = fifo_q[rd_q[PW-1:0]];
   // Skip stale heads whose status was already taken by start or halt
   assign ack_go     = !fifo_empty && pend_q[head];
   assign push       = ev_valid && !pend_q[ev_src_addr] && ((wr_q - rd_q) != (PW+1)'(DEPTH));
   // Pop on store of queue head, or drop a stale head
   assign pop        = !fifo_empty && (!pend_q[head] ||
                       (!store_q && !store_addr_q && ((bus.int_ack && int_en_q) ||
                        (is_cmd && bus.cmd_op == IOSQ_CMD_TEST))));

   // Refusal condition, one function used four times
   function automatic logic [1:0] start_cc(input logic [`IOSQ_SUB_W-1:0] s);
      if (!operational)                              start_cc = `IOSQ_CC_NOTOP;
      else if (busy_q[s] || store_q || store_addr_q) start_cc = `IOSQ_CC_BUSY;
      else                                           start_cc = `IOSQ_CC_OK;
   endfunction

   // ==========================================================
   // Queue pointers, oldest first keeps priority order
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_q <= '0;
         rd_q <= '0;
      end else if (is_cmd && bus.cmd_op == IOSQ_CMD_CTRL_RESET) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) wr_q <= wr_q + 1'b1;
         if (pop)  rd_q <= rd_q + 1'b1;
      end
   end

   always_ff @(posedge clk) begin
      if (push) fifo_q[wr_q[PW-1:0]] <= ev_src_addr;
   end

   // Status word: kind, flags, residue
   always_ff @(posedge clk) begin
      if (ev_valid) stat_q[ev_src_addr] <= {6'h00, ev_kind, 5'h00, ev_device_end,
                                            ev_area_full, ev_block_end, ev_residue};
   end

   // ==========================================================
   // Pending and busy per subchannel; event set wins over store clear, controller reset wins over both
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         pend_q <= '0;
         busy_q <= '0;
      end else begin
         for (int i = 0; i < SUBS; i++) begin
            if (is_cmd && bus.cmd_op == IOSQ_CMD_CTRL_RESET) begin
               pend_q[i] <= 1'b0;
               busy_q[i] <= 1'b0;
            end else if (ev_valid && ev_src_addr == i[`IOSQ_SUB_W-1:0]) begin
               pend_q[i] <= 1'b1;
               if (ev_device_end) busy_q[i] <= 1'b0;
            end else begin
               if (store_q && store_sub_q == i[`IOSQ_SUB_W-1:0]) pend_q[i] <= 1'b0;
               if (is_cmd && bus.cmd_op == IOSQ_CMD_START && sub == i[`IOSQ_SUB_W-1:0] &&
                   start_cc(sub) == `IOSQ_CC_OK)
                  busy_q[i] <= 1'b1;
            end
         end
      end
   end

   // ==========================================================
   // Status store sequencer: status word, then its address at vector+20
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         store_q      <= 1'b0;
         store_addr_q <= 1'b0;
         store_sub_q  <= '0;
      end else begin
         store_addr_q <= store_q;
         store_q      <= 1'b0;
         if (!store_q && !store_addr_q) begin
            if ((bus.int_ack && int_en_q && ack_go) ||
                (is_cmd && bus.cmd_op == IOSQ_CMD_TEST && ack_go)) begin
               store_q     <= 1'b1;
               store_sub_q <= head;
            end else if (is_cmd && (bus.cmd_op == IOSQ_CMD_START || bus.cmd_op == IOSQ_CMD_HALT)
                         && pend_q[sub]) begin
               store_q     <= 1'b1;
               store_sub_q <= sub;
            end
         end
      end
   end

   // Memory write port driven from flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus.mem_wr   <= 1'b0;
         bus.mem_addr <= '0;
         bus.mem_data <= '0;
      end else begin
         bus.mem_wr <= store_q || store_addr_q;
         if (store_q) begin
            bus.mem_addr <= buf_addr_q[`IOSQ_ADDR_W-1:0];
            bus.mem_data <= stat_q[store_sub_q];
         end else if (store_addr_q) begin
            bus.mem_addr <= vec_q[`IOSQ_ADDR_W-1:0] + `IOSQ_VEC_STATUS;
            bus.mem_data <= buf_addr_q;
         end
      end
   end

   // ==========================================================
   // Configuration: buffer address, vector, interrupt enable
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         buf_addr_q <= '0;
         vec_q      <= '0;
         int_en_q   <= 1'b0;
      end else if (is_cmd) begin
         if (bus.cmd_op == IOSQ_CMD_CHAN_CTRL) begin
            buf_addr_q <= bus.cmd_data;
            vec_q      <= {8'h00, bus.cmd_addr};
         end
         if (bus.cmd_op == IOSQ_CMD_ENABLE_INT)  int_en_q <= 1'b1;
         if (bus.cmd_op == IOSQ_CMD_DISABLE_INT) int_en_q <= 1'b0;
      end
   end

   // Command answer: condition code and status address
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         bus.cmd_done        <= 1'b0;
         bus.cmd_cc          <= `IOSQ_CC_OK;
         bus.cmd_status_addr <= '0;
      end else begin
         bus.cmd_done        <= is_cmd;
         // A channel control answer already shows the buffer that it sets up
         if (is_cmd && bus.cmd_op == IOSQ_CMD_CHAN_CTRL) bus.cmd_status_addr <= bus.cmd_data;
         else                                            bus.cmd_status_addr <= buf_addr_q;
         if (is_cmd) begin
            if (bus.cmd_op == IOSQ_CMD_UNDEF)      bus.cmd_cc <= `IOSQ_CC_UNDEF;
            else if (bus.cmd_op == IOSQ_CMD_START) bus.cmd_cc <= start_cc(sub);
            else if (!operational)                 bus.cmd_cc <= `IOSQ_CC_NOTOP;
            else                                   bus.cmd_cc <= `IOSQ_CC_OK;
         end
      end
   end

   // Request held while valid entries remain, stores included; the host
   // acknowledges only when idle, so no acknowledge meets a running store
   assign bus.int_req = int_en_q && ack_go;

   // ==========================================================
   // Controller-side strobes from flops
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ctl_start <= 1'b0;
         ctl_halt  <= 1'b0;
         ctl_reset <= 1'b0;
         ctl_sub   <= '0;
         ctl_cla   <= '0;
         xfer_done <= 1'b0;
      end else begin
         ctl_start <= is_cmd && bus.cmd_op == IOSQ_CMD_START && start_cc(sub) == `IOSQ_CC_OK;
         ctl_halt  <= is_cmd && bus.cmd_op == IOSQ_CMD_HALT;
         ctl_reset <= is_cmd && bus.cmd_op == IOSQ_CMD_CTRL_RESET;
         if (is_cmd) ctl_sub <= sub;
         // Private list address copy, loaded by accepted starts only
         if (is_cmd && bus.cmd_op == IOSQ_CMD_START && start_cc(sub) == `IOSQ_CC_OK)
            ctl_cla <= bus.cmd_data;
         xfer_done <= ev_valid && (ev_area_full || ev_block_end);
      end
   end
endmodule
`default_nettype wire

// *** verilog/iosq_host.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iosq_cfg.svh"
// ==========================================================
// Host end: issues one command at a time, acknowledges interrupts,
// keeps a shadow of the stored status address and context.
module iosq_host
   import iosq_pkg::*;
(
   input  wire logic                    clk,
   input  wire logic                    reset_n,
   iosq_if.host                         bus,
   input  wire logic                    req_valid,
   input  wire iosq_cmd_type            req_op,
   input  wire logic [`IOSQ_ADDR_W-1:0] req_addr,
   input  wire logic [`IOSQ_DATA_W-1:0] req_data,
   input  wire logic                    int_take,
   input  wire logic [`IOSQ_DATA_W-1:0] cur_psd,
   output logic                         req_ready,
   output logic                         rsp_valid,
   output logic [1:0]                   rsp_cc,
   output logic [`IOSQ_DATA_W-1:0]      rsp_status_addr,
   output logic                         int_serviced,
   output logic [`IOSQ_DATA_W-1:0]      saved_psd,
   output logic [`IOSQ_DATA_W-1:0]      saved_status_addr
);
   typedef enum logic [1:0] {IOSQ_H_IDLE, IOSQ_H_WAIT, IOSQ_H_ACK} iosq_h_type;
   iosq_h_type state_q;
   logic       wr_seen_q;

   assign req_ready = (state_q == IOSQ_H_IDLE);

   // ==========================================================
   // Command and acknowledge sequencer; one outstanding at a time
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         state_q       <= IOSQ_H_IDLE;
         bus.cmd_valid <= 1'b0;
         bus.cmd_op    <= IOSQ_CMD_TEST;
         bus.cmd_addr  <= '0;
         bus.cmd_data  <= '0;
         bus.int_ack   <= 1'b0;
      end else begin
         bus.int_ack <= 1'b0;
         case (state_q)
            IOSQ_H_IDLE: begin
               if (req_valid) begin
                  bus.cmd_valid <= 1'b1;
                  bus.cmd_op    <= req_op;
                  bus.cmd_addr  <= req_addr;
                  bus.cmd_data  <= req_data;
                  state_q       <= IOSQ_H_WAIT;
               end else if (int_take && bus.int_req) begin
                  bus.int_ack <= 1'b1;
                  state_q     <= IOSQ_H_ACK;
               end
            end
            IOSQ_H_WAIT: begin
               bus.cmd_valid <= 1'b0;
               if (bus.cmd_done) state_q <= IOSQ_H_IDLE;
            end
            IOSQ_H_ACK: begin
               // Second write of the store carries the status address
               if (bus.mem_wr && wr_seen_q) state_q <= IOSQ_H_IDLE;
            end
            default: state_q <= IOSQ_H_IDLE;
         endcase
      end
   end

   // First store write seen; the buffer may lie above the vector slot,
   // so write order, not address, tells the two writes apart
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wr_seen_q <= 1'b0;
      end else if (state_q != IOSQ_H_ACK) begin
         wr_seen_q <= 1'b0;
      end else if (bus.mem_wr) begin
         wr_seen_q <= 1'b1;
      end
   end

   // Answers and context save
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid         <= 1'b0;
         rsp_cc            <= `IOSQ_CC_OK;
         rsp_status_addr   <= '0;
         int_serviced      <= 1'b0;
         saved_psd         <= '0;
         saved_status_addr <= '0;
      end else begin
         rsp_valid    <= (state_q == IOSQ_H_WAIT) && bus.cmd_done;
         int_serviced <= 1'b0;
         if (bus.cmd_done) begin
            rsp_cc          <= bus.cmd_cc;
            rsp_status_addr <= bus.cmd_status_addr;
         end
         if (state_q == IOSQ_H_ACK && bus.mem_wr && wr_seen_q) begin
            saved_status_addr <= bus.mem_data;
            saved_psd         <= cur_psd;
            int_serviced      <= 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

// *** sim/iosq_checker.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iosq_cfg.svh"
// ==========================================================
// Link checks between the two ends
module iosq_checker
   import iosq_pkg::*;
(
   input wire logic         clk,
   input wire logic         reset_n,
   input wire logic         cmd_valid,
   input wire iosq_cmd_type cmd_op,
   input wire logic [23:0]  cmd_addr,
   input wire logic [31:0]  cmd_data,
   input wire logic         cmd_done,
   input wire logic [1:0]   cmd_cc,
   input wire logic [31:0]  cmd_status_addr,
   input wire logic         int_req,
   input wire logic         int_ack,
   input wire logic         mem_wr,
   input wire logic [23:0]  mem_addr,
   input wire logic [31:0]  mem_data
);
   logic [23:0]  vec_q;
   logic [31:0]  buf_q;
   iosq_cmd_type op_q;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);
   // Vector base and buffer as last set up by the host
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         vec_q <= 24'h0;
         buf_q <= 32'h0;
      end else if (cmd_valid && cmd_op == IOSQ_CMD_CHAN_CTRL) begin
         vec_q <= cmd_addr;
         buf_q <= cmd_data;
      end
   end
   // Last command, so its answer can be judged a cycle later
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n)
         op_q <= IOSQ_CMD_START;
      else if (cmd_valid)
         op_q <= cmd_op;
   end
   property p_done_cause;
      cmd_done |-> $past(cmd_valid);
   endproperty
   a_done_cause: assert property (p_done_cause) else $error("answer without command");
   property p_done_pulse;
      cmd_done |=> !cmd_done;
   endproperty
   a_done_pulse: assert property (p_done_pulse) else $error("answer longer than one cycle");
   property p_undef;
      cmd_done && op_q == IOSQ_CMD_UNDEF |-> cmd_cc == 2'h3;
   endproperty
   a_undef: assert property (p_undef) else $error("undefined command not refused");
   property p_stat;
      cmd_done |-> cmd_status_addr == buf_q;
   endproperty
   a_stat: assert property (p_stat) else $error("status address not given");
   property p_buf;
      mem_wr && !$past(mem_wr) |-> mem_addr == buf_q[23:0];
   endproperty
   a_buf: assert property (p_buf) else $error("status not at buffer");
   property p_vec;
      mem_wr && !$past(mem_wr) |=> mem_wr && mem_addr == vec_q + 24'h14 && mem_data == buf_q;
   endproperty
   a_vec: assert property (p_vec) else $error("status address not at vector slot");
   property p_ack;
      int_ack && int_req |-> ##[1:3] mem_wr;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge without store");
   property p_reset;
      cmd_done && op_q == IOSQ_CMD_CTRL_RESET |-> !int_req;
   endproperty
   a_reset: assert property (p_reset) else $error("request after controller reset");
endmodule
`default_nettype wire

// *** sim/tb.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "iosq_cfg.svh"
module tb;
   import iosq_pkg::*;
   localparam logic [23:0] VEC = 24'h000400;
   localparam logic [31:0] BUF = 32'h00001200;
   logic         clk = 1'b0, reset_n = 1'b0, operational = 1'b1, req_valid = 1'b0, int_take = 1'b0;
   logic         ev_valid = 1'b0, ev_device_end = 1'b0, ev_area_full = 1'b0, ev_block_end = 1'b0;
   logic [7:0]   ev_src_addr = 8'h0, ctl_sub, st_sub = 8'h0, esub = 8'h0;
   logic [1:0]   ev_kind = 2'h0, rsp_cc, last_cc = 2'h0;
   logic [15:0]  ev_residue = 16'h0;
   iosq_cmd_type req_op = IOSQ_CMD_TEST;
   logic [23:0]  req_addr = 24'h0;
   logic [31:0]  req_data = 32'h0, cur_psd = 32'h0, ctl_cla, rsp_status_addr, saved_psd, saved_status_addr;
   logic [31:0]  cla, ecla = 32'h0, st_cla = 32'h0;
   logic         ctl_start, ctl_halt, ctl_reset, xfer_done, req_ready, rsp_valid, int_serviced;
   int           num_errors = 0, n_checks = 0, rsp_n = 0, st_n = 0, hl_n = 0, rs_n = 0, sv_n = 0, x_n = 0;
   int           e_st = 0, e_hl = 0, e_rs = 0, e_sv = 0, e_x = 0, base;
   bit           prev_wr = 1'b0;
   bit           pend [256];
   bit           busy [256];
   int           pk [256];
   int           pq [$];
   logic [55:0]  eq [$], mq [$];
   iosq_if u_iosq_if ();
   iosq_channel #(.DEPTH(8)) u_iosq_channel (.clk, .reset_n, .bus(u_iosq_if), .operational, .ev_valid,
      .ev_src_addr, .ev_kind, .ev_device_end, .ev_area_full, .ev_block_end, .ev_residue, .ctl_start,
      .ctl_sub, .ctl_cla, .ctl_halt, .ctl_reset, .xfer_done);
   iosq_host u_iosq_host (.clk, .reset_n, .bus(u_iosq_if), .req_valid, .req_op, .req_addr, .req_data,
      .int_take, .cur_psd, .req_ready, .rsp_valid, .rsp_cc, .rsp_status_addr, .int_serviced, .saved_psd,
      .saved_status_addr);
   iosq_checker u_iosq_checker (.clk, .reset_n, .cmd_valid(u_iosq_if.cmd_valid), .cmd_op(u_iosq_if.cmd_op),
      .cmd_addr(u_iosq_if.cmd_addr), .cmd_data(u_iosq_if.cmd_data), .cmd_done(u_iosq_if.cmd_done),
      .cmd_cc(u_iosq_if.cmd_cc), .cmd_status_addr(u_iosq_if.cmd_status_addr), .int_req(u_iosq_if.int_req),
      .int_ack(u_iosq_if.int_ack), .mem_wr(u_iosq_if.mem_wr), .mem_addr(u_iosq_if.mem_addr),
      .mem_data(u_iosq_if.mem_data));
   // ==========================================================
   // Clock and output monitor
   always #10 clk = ~clk;
   // Status writes keep only the event code byte, since the rest is design detail
   always @(posedge clk) begin
      if (u_iosq_if.mem_wr === 1'b1)
         mq.push_back({u_iosq_if.mem_addr, prev_wr ? u_iosq_if.mem_data : {u_iosq_if.mem_data[31:24], 24'h0}});
      prev_wr = (u_iosq_if.mem_wr === 1'b1);
      if (rsp_valid === 1'b1)
         last_cc = rsp_cc;
      if (ctl_start === 1'b1)
         {st_sub, st_cla} = {ctl_sub, ctl_cla};
      rsp_n += (rsp_valid === 1'b1);
      st_n += (ctl_start === 1'b1);
      hl_n += (ctl_halt === 1'b1);
      rs_n += (ctl_reset === 1'b1);
      sv_n += (int_serviced === 1'b1);
      x_n += (xfer_done === 1'b1);
   end
   // ==========================================================
   // Checking and reference model
   task automatic chk(input string what, input logic [55:0] seen, input logic [55:0] exp);
      n_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
      end
   endtask
   task automatic results();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic hang();
      num_errors++;
      results();
   endtask
   // Model store: status word then its address, entry dropped everywhere
   task automatic store(input int s);
      eq.push_back({BUF[23:0], 8'(pk[s]), 24'h0});
      eq.push_back({VEC + 24'h14, BUF});
      pend[s] = 1'b0;
      for (int i = pq.size() - 1; i >= 0; i--)
         if (pq[i] == s)
            pq.delete(i);
   endtask
   task automatic drain();
      repeat (6) @(negedge clk);
      chk("write count", 56'(mq.size()), 56'(eq.size()));
      while (mq.size() > 0 && eq.size() > 0)
         chk("memory write", mq.pop_front(), eq.pop_front());
      mq.delete();
      eq.delete();
   endtask
   // One event pulse, one device at a time as one controller serves one
   // x bit 1 area full, bit 0 block end
   task automatic ev(input int s, input int k, input bit de, input bit [1:0] x);
      @(negedge clk);
      {ev_valid, ev_src_addr, ev_kind, ev_device_end, ev_area_full, ev_block_end} = {1'b1, 8'(s), 2'(k), de, x};
      ev_residue = 16'($urandom);
      if (de)
         busy[s] = 1'b0;
      if (!pend[s])
         pq.push_back(s);
      {pend[s], pk[s]} = {1'b1, k};
      e_x += (x != 2'h0);
      @(negedge clk);
      {ev_valid, ev_area_full, ev_block_end} = 3'h0;
   endtask
   task automatic cmd(input iosq_cmd_type op, input int s, input logic [31:0] d);
      int n;
      int r0;
      logic [1:0] ecc;
      ecc = 2'h0;
      n = 0;
      while (req_ready !== 1'b1 && n < 100) begin
         @(negedge clk);
         n++;
      end
      if (n == 100)
         hang();
      req_valid = 1'b1;
      req_op    = op;
      req_data  = d;
      req_addr = (op == IOSQ_CMD_CHAN_CTRL) ? VEC : {16'h0, 8'(s)};
      r0 = rsp_n;
      @(negedge clk);
      req_valid = 1'b0;
      while (rsp_n == r0 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n == 200)
         hang();
      case (op)
         IOSQ_CMD_START: begin
            if (pend[s])
               store(s);
            ecc = !operational ? 2'h2 : busy[s] ? 2'h1 : 2'h0;
            if (ecc == 2'h0)
               {busy[s], e_st, ecla, esub} = {1'b1, e_st + 1, d, 8'(s)};
         end
         IOSQ_CMD_HALT: begin
            if (pend[s])
               store(s);
            e_hl++;
         end
         IOSQ_CMD_TEST: if (pq.size() > 0)
            store(pq[0]);
         IOSQ_CMD_CTRL_RESET: begin
            pq.delete();
            pend = '{default: 1'b0};
            e_rs++;
         end
         IOSQ_CMD_UNDEF: ecc = 2'h3;
         default: ;
      endcase
      drain();
      chk("cc", last_cc, ecc);
      chk("starts", st_n, e_st);
      chk("halts", hl_n, e_hl);
      chk("resets", rs_n, e_rs);
      chk("started sub", st_sub, esub);
      chk("list address", st_cla, ecla);
   endtask
   // Acknowledge until the request drops; model takes the queue in order
   task automatic service();
      int n;
      chk("request", u_iosq_if.int_req, 1);
      cur_psd = $urandom;
      while (pq.size() > 0) begin
         store(pq[0]);
         e_sv++;
      end
      int_take = 1'b1;
      n = 0;
      while (u_iosq_if.int_req !== 1'b0 && n < 200) begin
         @(negedge clk);
         n++;
      end
      if (n == 200)
         hang();
      int_take = 1'b0;
      drain();
      chk("serviced", sv_n, e_sv);
      chk("saved psd", saved_psd, cur_psd);
      chk("saved status address", saved_status_addr, BUF);
   endtask
   // ==========================================================
   // Main sequence
   initial begin
      void'($urandom(1));
      base = $urandom_range(200, 0);
      cla = $urandom;
      repeat (12) @(posedge clk);
      @(negedge clk);
      reset_n = 1'b1;
      chk("request after reset", u_iosq_if.int_req, 0);
      cmd(IOSQ_CMD_CHAN_CTRL, 0, BUF);
      chk("status address", rsp_status_addr, BUF);
      cmd(IOSQ_CMD_ENABLE_INT, 0, 32'h0);
      cmd(IOSQ_CMD_START, base, cla);
      cmd(IOSQ_CMD_START, base, cla + 32'h4);
      operational = 1'b0;
      cmd(IOSQ_CMD_START, base + 1, cla + 32'h8);
      operational = 1'b1;
      cmd(IOSQ_CMD_UNDEF, base + 2, cla);
      ev(base, 0, 1'b1, 2'h1);
      ev(base + 1, 1, 1'b0, 2'h2);
      ev(base + 2, 2, 1'b0, 2'h0);
      chk("transfer ends", x_n, e_x);
      service();
      cmd(IOSQ_CMD_START, base, cla + 32'h10);
      cmd(IOSQ_CMD_DISABLE_INT, 0, 32'h0);
      ev(base + 3, 0, 1'b0, 2'h0);
      int_take = 1'b1;
      repeat (10) @(negedge clk);
      int_take = 1'b0;
      drain();
      chk("request disabled", u_iosq_if.int_req, 0);
      cmd(IOSQ_CMD_TEST, base + 3, $urandom);
      ev(base + 4, 1, 1'b0, 2'h0);
      ev(base + 5, 2, 1'b0, 2'h0);
      cmd(IOSQ_CMD_HALT, base + 5, 32'h0);
      cmd(IOSQ_CMD_TEST, 0, 32'h0);
      cmd(IOSQ_CMD_TEST, 0, 32'h0);
      ev(base + 6, 0, 1'b0, 2'h0);
      ev(base + 7, 1, 1'b0, 2'h0);
      cmd(IOSQ_CMD_START, base + 7, cla);
      cmd(IOSQ_CMD_CTRL_RESET, base + 6, 32'h0);
      cmd(IOSQ_CMD_ENABLE_INT, 0, 32'h0);
      chk("request after clear", u_iosq_if.int_req, 0);
      cmd(IOSQ_CMD_TEST, 0, 32'h0);
      results();
   end
endmodule
`default_nettype wire
